/* adc_host_if.sv */
`timescale 1ns/100ps
`include "adc_params.svh"

module adc_host_if
    import adc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic [7:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    input  wire logic [7:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    input  wire logic        CONVERSION_START_N_I,
    input  wire logic        DEVICE_SELECT_N_I,
    input  wire logic        READ_N_I,
    input  wire logic        SCLK_IN_I,
    input  wire logic [15:0] SAMPLE_CODE_I,
    output logic [15:0]      DATA_O,
    output logic [15:0]      DATA_OE_N_O,
    output logic             BUSY_O,
    output logic             REF_ON_O,
    output logic             BUF_ON_O,
    output logic             LOW_POWER_O,
    output logic             IRQ_O
);

    logic [`CTRL_WIDTH-1:0] ctrl;
    logic [`IRQ_WIDTH-1:0]  irq_stat;
    logic [`IRQ_WIDTH-1:0]  irq_mask;
    logic                   soft_rst;
    logic                   aw_held;
    logic                   w_held;
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   do_write;
    logic                   do_read;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;
    logic                   ser_sel;
    logic                   clk_ext;
    conv_state_t            state;
    logic [11:0]            cnt;
    logic [15:0]            held_code;
    logic [15:0]            result;
    logic                   conv_end;
    logic                   unread;
    logic [15:0]            shreg;
    logic [4:0]             bit_cnt;
    logic                   int_active;
    logic                   sclk_int;
    logic [7:0]             div_cnt;
    logic                   half_tick;
    logic                   ext_edge;
    logic                   ext_started;
    logic                   rd_err_evt;
    logic [7:0]             rderr_cnt;
    logic                   cnv_lvl;
    logic                   cnv_fall;
    logic                   cs_n_lvl;
    logic                   rd_n_lvl;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   bus_en;
    logic [15:0]            next_data;
    logic [15:0]            next_oe_n;

    pin_sync u_sync_cnv (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .pin_i   (CONVERSION_START_N_I),
        .level_o (cnv_lvl),
        .rise_o  (),
        .fall_o  (cnv_fall)
    );

    pin_sync u_sync_cs (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .pin_i   (DEVICE_SELECT_N_I),
        .level_o (cs_n_lvl),
        .rise_o  (),
        .fall_o  ()
    );

    pin_sync u_sync_rd (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .pin_i   (READ_N_I),
        .level_o (rd_n_lvl),
        .rise_o  (),
        .fall_o  ()
    );

    pin_sync #(.INIT(1'b0)) u_sync_sclk (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .pin_i   (SCLK_IN_I),
        .level_o (),
        .rise_o  (sclk_rise),
        .fall_o  (sclk_fall)
    );

    // Register slave
    assign AWREADY_O = ~aw_held;
    assign WREADY_O  = ~w_held;
    assign ARREADY_O = ~RVALID_O;
    assign do_write  = aw_held & w_held & ~BVALID_O;
    assign do_read   = ARVALID_I & ~RVALID_O;

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O  <= `RESP_OKAY;
        end
        else
        begin
            if (AWVALID_I && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR_I;
            end
            if (WVALID_I && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= WDATA_I;
                w_strb <= WSTRB_I;
            end
            if (do_write)
            begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                BVALID_O <= 1'b1;
                BRESP_O  <= (aw_addr[7:2] == `REG_CTRL >> 2 ||
                             aw_addr[7:2] == `REG_IRQ_MASK >> 2) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (BREADY_I)
            begin
                BVALID_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl     <= `CTRL_RESET;
            irq_mask <= '0;
            soft_rst <= 1'b0;
        end
        else
        begin
            soft_rst <= 1'b0;
            if (do_write && w_strb[0] && aw_addr[7:2] == `REG_CTRL >> 2)
            begin
                ctrl     <= w_data[`CTRL_WIDTH-1:0];
                soft_rst <= w_data[`CTRL_SOFT_RST];
            end
            if (do_write && w_strb[0] && aw_addr[7:2] == `REG_IRQ_MASK >> 2)
            begin
                irq_mask <= w_data[`IRQ_WIDTH-1:0];
            end
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `RESP_OKAY;
        unique case (ARADDR_I[7:2])
            `REG_CTRL >> 2:     next_rdata[`CTRL_WIDTH-1:0] = ctrl;
            `REG_STATUS >> 2:
            begin
                next_rdata[`STAT_BUSY]    = BUSY_O;
                next_rdata[`STAT_PDOWN]   = (state == ST_PDOWN);
                next_rdata[`STAT_READING] = int_active | ext_started;
            end
            `REG_RESULT >> 2:   next_rdata[15:0] = result;
            `REG_IRQ_STAT >> 2: next_rdata[`IRQ_WIDTH-1:0] = irq_stat;
            `REG_IRQ_MASK >> 2: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
            default:            next_rresp = `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            RVALID_O <= 1'b0;
            RDATA_O  <= 32'h0000_0000;
            RRESP_O  <= `RESP_OKAY;
        end
        else if (do_read)
        begin
            RVALID_O <= 1'b1;
            RDATA_O  <= next_rdata;
            RRESP_O  <= next_rresp;
        end
        else if (RREADY_I)
        begin
            RVALID_O <= 1'b0;
        end
    end

    // Interrupt status: a new event wins over the read clear
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            irq_stat <= '0;
        end
        else
        begin
            if (do_read && ARADDR_I[7:2] == `REG_IRQ_STAT >> 2)
            begin
                irq_stat <= '0;
            end
            if (conv_end)
            begin
                irq_stat[`IRQ_DONE] <= 1'b1;
            end
            if (rd_err_evt)
            begin
                irq_stat[`IRQ_RDERR] <= 1'b1;
            end
        end
    end

    assign IRQ_O = |(irq_stat & irq_mask);

    // Conversion sequencer
    assign ser_sel  = ctrl[`CTRL_SER_SEL];
    assign clk_ext  = ctrl[`CTRL_CLK_SRC];
    assign conv_end = (state == ST_CONV) && (cnt == 12'(`CONV_CYCLES - 1));

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state     <= ST_ACQ;
            cnt       <= 12'h000;
            held_code <= 16'h0000;
            result    <= 16'h0000;
            BUSY_O    <= 1'b0;
        end
        else if (soft_rst)
        begin
            state  <= ST_ACQ;
            cnt    <= 12'h000;
            BUSY_O <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_ACQ:
                begin
                    cnt <= cnt + 12'h001;
                    if (cnt == 12'(`ACQ_CYCLES - 1))
                    begin
                        cnt <= 12'h000;
                        if (ctrl[`CTRL_PWR_DOWN])
                        begin
                            state <= ST_PDOWN;
                        end
                        else if (!cnv_lvl)
                        begin
                            state     <= ST_CONV;
                            held_code <= SAMPLE_CODE_I;
                            BUSY_O    <= 1'b1;
                        end
                        else
                        begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT:
                begin
                    if (ctrl[`CTRL_PWR_DOWN])
                    begin
                        state <= ST_PDOWN;
                    end
                    else if (cnv_fall)
                    begin
                        state     <= ST_CONV;
                        held_code <= SAMPLE_CODE_I;
                        BUSY_O    <= 1'b1;
                    end
                end
                ST_CONV:
                begin
                    cnt <= cnt + 12'h001;
                    if (conv_end)
                    begin
                        cnt    <= 12'h000;
                        result <= held_code;
                        BUSY_O <= 1'b0;
                        state  <= ctrl[`CTRL_PWR_DOWN] ? ST_PDOWN : ST_ACQ;
                    end
                end
                ST_PDOWN:
                begin
                    if (!ctrl[`CTRL_PWR_DOWN])
                    begin
                        state <= ST_ACQ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            LOW_POWER_O <= 1'b0;
            REF_ON_O    <= 1'b1;
            BUF_ON_O    <= 1'b1;
        end
        else
        begin
            LOW_POWER_O <= (state == ST_PDOWN);
            REF_ON_O    <= ~ctrl[`CTRL_REF_OFF];
            BUF_ON_O    <= ~ctrl[`CTRL_BUF_OFF];
        end
    end

    // Serial port
    assign bus_en      = ~cs_n_lvl & ~rd_n_lvl;
    assign ext_edge    = ser_sel & clk_ext & ~cs_n_lvl &
                         (ctrl[`CTRL_SCLK_INV] ? sclk_fall : sclk_rise);
    assign ext_started = clk_ext && bit_cnt != 5'd0 && bit_cnt != 5'(`RESULT_BITS);
    assign rd_err_evt  = conv_end & ser_sel & ext_started;
    assign half_tick   = int_active && div_cnt == 8'(`SCLK_HALF_CYCLES - 1);

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            shreg      <= 16'h0000;
            bit_cnt    <= 5'd0;
            unread     <= 1'b0;
            int_active <= 1'b0;
            sclk_int   <= 1'b0;
            div_cnt    <= 8'h00;
        end
        else if (soft_rst)
        begin
            bit_cnt    <= 5'd0;
            unread     <= 1'b0;
            int_active <= 1'b0;
            sclk_int   <= 1'b0;
            div_cnt    <= 8'h00;
        end
        else if (conv_end)
        begin
            shreg      <= held_code;
            bit_cnt    <= 5'd0;
            unread     <= 1'b1;
            int_active <= 1'b0;
            sclk_int   <= 1'b0;
            div_cnt    <= 8'h00;
        end
        else if (ext_edge && bit_cnt != 5'(`RESULT_BITS))
        begin
            shreg   <= {shreg[14:0], 1'b0};
            bit_cnt <= bit_cnt + 5'd1;
            unread  <= 1'b0;
        end
        else if (!int_active)
        begin
            if (ser_sel && !clk_ext && bus_en && unread)
            begin
                int_active <= 1'b1;
                unread     <= 1'b0;
            end
        end
        else
        begin
            div_cnt <= half_tick ? 8'h00 : div_cnt + 8'h01;
            if (half_tick)
            begin
                sclk_int <= ~sclk_int;
                if (sclk_int)
                begin
                    shreg   <= {shreg[14:0], 1'b0};
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == 5'(`RESULT_BITS - 1))
                    begin
                        int_active <= 1'b0;
                        bit_cnt    <= 5'd0;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rderr_cnt <= 8'h00;
        end
        else if (soft_rst)
        begin
            rderr_cnt <= 8'h00;
        end
        else if (rd_err_evt)
        begin
            rderr_cnt <= 8'(`RDERR_CYCLES);
        end
        else if (rderr_cnt != 8'h00)
        begin
            rderr_cnt <= rderr_cnt - 8'h01;
        end
    end

    // Pin multiplexing
    always_comb
    begin
        next_data = result;
        next_oe_n = bus_en ? 16'h0000 : 16'hffff;
        if (ser_sel)
        begin
            next_data[`PIN_SER_DATA] = shreg[15];
            next_data[`PIN_SCLK]  = sclk_int;
            next_data[`PIN_SYNC]  = int_active ^ ctrl[`CTRL_SYNC_INV];
            next_data[`PIN_RDERR] = (rderr_cnt != 8'h00);
            next_oe_n[7:0]        = 8'hff;
            if (clk_ext)
            begin
                next_oe_n[`PIN_SCLK] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            DATA_O      <= 16'h0000;
            DATA_OE_N_O <= 16'hffff;
        end
        else
        begin
            DATA_O      <= next_data;
            DATA_OE_N_O <= next_oe_n;
        end
    end

endmodule // adc_host_if

/* adc_params.svh */
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Clock and timing
`define CLK_FREQ_MHZ        200
`define ACQ_TIME_NS         2000
`define CONV_TIME_NS        8000
`define SCLK_HALF_NS        40
`define RDERR_TIME_NS       80
`define ACQ_CYCLES          ((`ACQ_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define CONV_CYCLES         ((`CONV_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SCLK_HALF_CYCLES    ((`SCLK_HALF_NS * `CLK_FREQ_MHZ) / 1000)
`define RDERR_CYCLES        ((`RDERR_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RESULT_BITS         16

// Register byte offsets
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_RESULT          8'h08
`define REG_IRQ_STAT        8'h0c
`define REG_IRQ_MASK        8'h10

// Control register fields
`define CTRL_SER_SEL        0
`define CTRL_CLK_SRC        1
`define CTRL_SYNC_INV       2
`define CTRL_SCLK_INV       3
`define CTRL_PWR_DOWN       4
`define CTRL_REF_OFF        5
`define CTRL_BUF_OFF        6
`define CTRL_SOFT_RST       7
`define CTRL_WIDTH          7
`define CTRL_RESET          7'h00

// Status and interrupt fields
`define STAT_BUSY           0
`define STAT_PDOWN          1
`define STAT_READING        2
`define IRQ_DONE            0
`define IRQ_RDERR           1
`define IRQ_WIDTH           2

// Shared pin positions
`define PIN_SER_DATA        8
`define PIN_SCLK            9
`define PIN_SYNC            10
`define PIN_RDERR           11

// Bus responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

/* adc_pkg.sv */
package adc_pkg;

    typedef enum logic [1:0]
    {
        ST_ACQ,
        ST_WAIT,
        ST_CONV,
        ST_PDOWN
    } conv_state_t;

endpackage

/* pin_sync.sv */
`timescale 1ns/100ps

module pin_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta;
    logic prev;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta    <= INIT;
            level_o <= INIT;
            prev    <= INIT;
        end
        else
        begin
            meta    <= pin_i;
            level_o <= meta;
            prev    <= level_o;
        end
    end

    assign rise_o = level_o & ~prev;
    assign fall_o = ~level_o & prev;

endmodule // pin_sync

/* adc_host_if_chk.sv */
`timescale 1ns/100ps
module adc_host_if_chk (
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CONVERSION_START_N_I,
    input  wire logic        DEVICE_SELECT_N_I,
    input  wire logic        READ_N_I,
    input  wire logic [15:0] DATA_OE_N_O,
    input  wire logic        BUSY_O,
    input  wire logic        LOW_POWER_O
);
    logic [11:0] busy_cnt;
    logic [9:0]  idle_cnt;
    logic [5:0]  start_hist;
    wire         sel_rd = !DEVICE_SELECT_N_I && !READ_N_I;
    // Busy span length
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I || !BUSY_O)
            busy_cnt <= 12'h000;
        else
            busy_cnt <= busy_cnt + 12'h001;
    end
    // Idle span length, saturating
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I || BUSY_O)
            idle_cnt <= 10'h000;
        else if (idle_cnt != 10'h3ff)
            idle_cnt <= idle_cnt + 10'h001;
    end
    // Recent start pin history
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            start_hist <= 6'h00;
        else
            start_hist <= {start_hist[4:0], !CONVERSION_START_N_I};
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    busy_len_a: assert property ($fell(BUSY_O) |-> busy_cnt == 12'h640)
        else $error("busy span not 1600 cycles");
    oe_enable_a: assert property (!DATA_OE_N_O[12] |->
        $past(sel_rd, 2) || $past(sel_rd, 3) || $past(sel_rd, 4))
        else $error("bus enabled without select and read");
    oe_release_a: assert property ((!sel_rd) [*5] |-> DATA_OE_N_O[12])
        else $error("bus still enabled after release");
    oe_group_a: assert property (DATA_OE_N_O[15:10] == {6{DATA_OE_N_O[8]}})
        else $error("shared output bits not enabled together");
    low_bits_a: assert property (DATA_OE_N_O[7:0] == 8'hff ||
        DATA_OE_N_O[7:0] == {8{DATA_OE_N_O[15]}})
        else $error("low bits enabled in wrong mode");
    start_cause_a: assert property ($rose(BUSY_O) |-> |start_hist)
        else $error("conversion without start low");
    acq_gap_a: assert property ($rose(BUSY_O) |-> idle_cnt >= 10'h190)
        else $error("acquisition shorter than 400 cycles");
    pd_block_a: assert property ($rose(BUSY_O) |-> !$past(LOW_POWER_O))
        else $error("conversion started in power-down");
    cover property ($fell(BUSY_O));
    cover property (!DATA_OE_N_O[9] && !DATA_OE_N_O[8]);
    cover property ($rose(LOW_POWER_O));
endmodule // adc_host_if_chk

bind adc_host_if adc_host_if_chk chk (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CONVERSION_START_N_I(CONVERSION_START_N_I),
    .DEVICE_SELECT_N_I(DEVICE_SELECT_N_I), .READ_N_I(READ_N_I),
    .DATA_OE_N_O(DATA_OE_N_O), .BUSY_O(BUSY_O), .LOW_POWER_O(LOW_POWER_O)
);

/* host_model.sv */
`timescale 1ns/100ps
module host_model (
    input  wire logic clk_i,
    input  wire logic sdata_i,
    output logic      start_n_o,
    output logic      cs_n_o,
    output logic      rd_n_o,
    output logic      sclk_o
);
    logic [15:0] got;
    initial
    begin
        start_n_o = 1'b1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        sclk_o = 1'b0;
        got = 16'h0000;
    end
    // Control pins change just after a clock edge
    task pins(input logic st, input logic cs, input logic rd);
        @(posedge clk_i);
        start_n_o <= st;
        cs_n_o <= cs;
        rd_n_o <= rd;
    endtask
    // Burst of active edges at 160 ns, clock stands still outside
    task burst(input int n, input logic inv);
        sclk_o = inv;
        #37.3;
        repeat (n)
        begin
            got = {got[14:0], sdata_i};
            #80 sclk_o = ~inv;
            #80 sclk_o = inv;
        end
    endtask
endmodule // host_model

/* tb_top.sv */
`timescale 1ns/100ps
`include "adc_params.svh"
module tb_top;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, d;
    logic [31:0] seed;
    wire  [31:0] rdata;
    wire  [1:0]  bresp, rresp;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         busy, ref_on, buf_on, low_pw, irq, start_n, cs_n, rd_n, sclk;
    logic [15:0] sample, c, c2, g;
    wire  [15:0] dout, doe_n;
    logic [1:0]  r;
    int          n_errors, samples_checked, i, n;
    adc_host_if DUT (.CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .CONVERSION_START_N_I(start_n), .DEVICE_SELECT_N_I(cs_n), .READ_N_I(rd_n),
        .SCLK_IN_I(sclk), .SAMPLE_CODE_I(sample), .DATA_O(dout), .DATA_OE_N_O(doe_n),
        .BUSY_O(busy), .REF_ON_O(ref_on), .BUF_ON_O(buf_on), .LOW_POWER_O(low_pw),
        .IRQ_O(irq));
    host_model host (.clk_i(clk), .sdata_i(dout[8] ^ doe_n[8]), .start_n_o(start_n),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk));
    always #2.5 clk = ~clk;
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid || !bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task wb(input logic lvl, output int k);
        k = 0;
        while (busy !== lvl && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    // One conversion; edge_mode keeps start high past acquisition end
    task conv(input logic [15:0] v, input logic edge_mode, output int k);
        sample <= v;
        if (edge_mode)
        begin
            repeat (450) @(posedge clk);
            check("no start", busy, 1'b0);
        end
        host.pins(1'b0, host.cs_n_o, host.rd_n_o);
        wb(1'b1, k);
        if (edge_mode) check("start delay", k <= 6, 1'b1);
        host.pins(1'b1, host.cs_n_o, host.rd_n_o);
        sample <= ~v;
        wb(1'b0, i);
        check("busy width", i + 1, `CONV_CYCLES);
    endtask
    task test_done;
        $display("Checked %0d values, %0d mismatches", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole run needs about 28k cycles
    initial
    begin
        #400000;
        n_errors++;
        test_done;
    end
    initial
    begin
        {clk, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, sample} = 64'h0;
        seed = 32'h41bc;
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("reset pins", {busy, ref_on, buf_on, low_pw, irq, doe_n}, 21'h0cffff);
        rd(`REG_CTRL, d, r);
        check("ctrl reset", d, 32'h0);
        rd(`REG_IRQ_MASK, d, r);
        check("mask reset", d, 32'h0);
        rd(8'h14, d, r);
        check("unmapped", {r, d}, {`RESP_SLVERR, 32'h0});
        wr(`REG_STATUS, 32'h1, r);
        check("ro write", r, `RESP_SLVERR);
        c = 16'h8001;
        conv(c, 1'b0, n);
        rd(`REG_RESULT, d, r);
        check("result reg", d, {16'h0, c});
        host.pins(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        check("par data", {doe_n, dout}, {16'h0, c});
        check("irq masked", irq, 1'b0);
        wr(`REG_IRQ_MASK, 32'h3, r);
        check("irq on", irq, 1'b1);
        rd(`REG_IRQ_STAT, d, r);
        check("irq stat", d[1:0], 2'b01);
        @(posedge clk);
        check("irq clear", irq, 1'b0);
        host.pins(1'b1, 1'b1, 1'b1);
        conv(rnd(), 1'b1, n);
        conv(rnd(), 1'b0, n);
        check("acq start", n >= 399 && n <= 404, 1'b1);
        $display("Test parallel finished");
        for (int m = 0; m < 2; m++)
        begin
            wr(`REG_CTRL, 32'h1 | (m << 2), r);
            c = rnd();
            conv(c, 1'b0, n);
            host.pins(1'b1, 1'b0, 1'b0);
            repeat (16)
            begin
                while (dout[9] !== 1'b0) @(posedge clk);
                while (dout[9] !== 1'b1) @(posedge clk);
                g = {g[14:0], dout[8]};
                check("sync hold", {doe_n[9], dout[10]}, {1'b0, !m[0]});
            end
            check("serial int", g, c);
            check("high bits", {doe_n[15:12], dout[15:12]}, {4'h0, c[15:12]});
            repeat (20) @(posedge clk);
            check("sync end", dout[10], m[0]);
            wr(`REG_CTRL, 32'h3 | (m << 3), r);
            c = rnd();
            conv(c, 1'b0, n);
            host.pins(1'b1, 1'b1, 1'b0);
            host.burst(3, m[0]);
            host.pins(1'b1, 1'b0, 1'b0);
            host.burst(16, m[0]);
            check("serial ext", host.got, c);
            conv(rnd(), 1'b0, n);
            host.burst(5, m[0]);
            c2 = rnd();
            conv(c2, 1'b0, n);
            n = 0;
            repeat (40)
            begin
                n += (dout[11] === 1'b1);
                @(posedge clk);
            end
            check("error pulse", n, 16);
            host.burst(16, m[0]);
            check("new result", host.got, c2);
            rd(`REG_IRQ_STAT, d, r);
            check("error irq", d[1], 1'b1);
            host.pins(1'b1, 1'b1, 1'b1);
        end
        $display("Test serial finished");
        wr(`REG_CTRL, 32'h0, r);
        host.pins(1'b0, 1'b1, 1'b1);
        wb(1'b1, n);
        rd(`REG_STATUS, d, r);
        check("status busy", d[2:0], 3'b001);
        wr(`REG_CTRL, 32'h70, r);
        repeat (2) @(posedge clk);
        check("ref off", {ref_on, buf_on}, 2'b00);
        wb(1'b0, n);
        n = 0;
        repeat (2500)
        begin
            @(posedge clk);
            n += (busy === 1'b1);
        end
        check("pd refuse", {n, low_pw}, {32'h0, 1'b1});
        rd(`REG_STATUS, d, r);
        check("status pd", d[2:0], 3'b010);
        wr(`REG_CTRL, 32'h0, r);
        @(posedge clk);
        check("ref on", {ref_on, buf_on}, 2'b11);
        wb(1'b1, n);
        rst <= 1'b1;
        @(posedge clk);
        check("reset abort", {busy, doe_n}, {1'b0, 16'hffff});
        rst <= 1'b0;
        wb(1'b1, n);
        check("reset acq", n >= 400, 1'b1);
        $display("Test power and reset finished");
        test_done;
    end
endmodule // tb_top
